// ---- src/expander_map.svh ----
// What this block does
// - answer only slave addresses 101 followed by four select-derived bits
// - each written data byte sets all eight outputs, bit 7 to output 7
// - reads return the actual pin levels, including externally forced ones
// - reset pin aborts any transaction and returns the interface to idle
// - reset pin leaves the output byte and the pins unchanged
// - slave address is re-evaluated on every bus transmission
// - each select input classed as GND, supply, SDA or SCL; two give sixteen
// - before the first transmission, SDA or SCL ties count as high
// - low select sets outputs 3..0 at power-up, high select outputs 7..4
// - high, SDA or SCL tie gives high defaults; low tie gives low defaults
// - in a write, every data byte is acknowledged and updates the outputs
// - in a read, pins are sampled at each acknowledge and sent next
`ifndef EXPANDER_MAP_SVH
`define EXPANDER_MAP_SVH

`define ADDR_HI3 3'h5
`define PORT_RESET 8'h00
`define GROUP_HIGH 4'hF
`define GROUP_LOW 4'h0
`define STRAP_WAIT 2'h3
`define STRAP_DONE 2'h0
`define STRAP_STEP 2'h1
`define RISE_ZERO 4'h0
`define RISE_ONE 4'h1
`define RISE_ADDR_SNAP 4'h7
`define RISE_LAST_BIT 4'h8
`define RISE_ACK 4'h9
`define FALL_ZERO 4'h0
`define FALL_ONE 4'h1
`define FALL_BYTE 4'h8
`define FALL_ACK 4'h9
`define SEL_LOW 0
`define SEL_HIGH 1

`endif

// ---- src/expander_pkg.sv ----
package expander_pkg;

    typedef enum logic [1:0] {PC_GND, PC_VCC, PC_SDA, PC_SCL} pin_class_t;

    typedef enum logic [1:0] {PH_ADDR, PH_WRITE, PH_READ, PH_SKIP} link_phase_t;

    // link to core: last written byte and its event toggle
    typedef struct packed {
        logic [7:0] wr_byte;
        logic wr_tgl;
    } link_up_t;

    // core to link: words held stable while the link reads them
    typedef struct packed {
        logic [3:0] slave_low4;
        logic [7:0] rd_byte;
    } link_down_t;

    typedef struct packed {
        link_phase_t phase;
        logic armed;
        logic [3:0] fall_cnt;
        logic [7:0] shreg;
        logic rw;
        logic sda_oe;
        link_up_t up;
    } link_state_t;

    typedef struct packed {
        logic [1:0] scl_m;
        logic [1:0] sda_m;
        logic [1:0] rstp_m;
        logic [1:0][1:0] sel_m;
        logic [7:0] pins_a;
        logic [7:0] pins_b;
        logic [1:0] wtg_m;
        logic wtg_d;
        logic scl_d;
        logic sda_d;
        logic busy;
        logic link_clr;
        logic [2:0] clr_hist;
        logic [3:0] rise_cnt;
        logic first_byte;
        logic framed_once;
        logic [1:0] diff_scl;
        logic [1:0] diff_sda;
        pin_class_t [1:0] cls;
        link_down_t down;
        logic [7:0] port;
        logic [1:0] strap_wait;
        logic strap_pend;
        logic sda_o;
    } core_state_t;

endpackage

// ---- src/i2c_link.sv ----
`timescale 1ns/100ps
`include "expander_map.svh"

// serial engine on the falling edge of scl; link_clr is held by the core
// from STOP or pin reset to START and pulsed on a repeated START, while scl is high except for a pin reset
module i2c_link (
    input wire logic scl,
    input wire logic link_clr,
    input wire logic sda_i,
    input expander_pkg::link_down_t down,
    output expander_pkg::link_up_t up,
    output logic sda_oe
);
    import expander_pkg::*;

    link_state_t s_r;
    link_state_t s_nxt;
    logic [3:0] n;
    logic [7:0] full;

    always_comb begin
        s_nxt = s_r;
        n = s_r.fall_cnt + `FALL_ONE;
        full = {s_r.shreg[6:0], sda_i};
        if (!s_r.armed) begin
            // first fall belongs to the START itself
            s_nxt.armed = 1'b1;
            s_nxt.fall_cnt = `FALL_ZERO;
        end else if (n == `FALL_BYTE) begin
            s_nxt.fall_cnt = n;
            unique case (s_r.phase)
                PH_ADDR: begin
                    s_nxt.shreg = full;
                    s_nxt.rw = sda_i;
                    if (full[7:1] == {`ADDR_HI3, down.slave_low4}) begin
                        s_nxt.sda_oe = 1'b1;
                    end else begin
                        s_nxt.phase = PH_SKIP;
                    end
                end
                PH_WRITE: begin
                    s_nxt.shreg = full;
                    s_nxt.up.wr_byte = full;
                    s_nxt.up.wr_tgl = ~s_r.up.wr_tgl;
                    s_nxt.sda_oe = 1'b1;
                end
                PH_READ: begin
                    // free the line for the master's acknowledge
                    s_nxt.sda_oe = 1'b0;
                end
                PH_SKIP: begin
                    s_nxt.sda_oe = 1'b0;
                end
            endcase
        end else if (n == `FALL_ACK) begin
            s_nxt.fall_cnt = `FALL_ZERO;
            s_nxt.sda_oe = 1'b0;
            unique case (s_r.phase)
                PH_ADDR: begin
                    if (s_r.rw) begin
                        s_nxt.phase = PH_READ;
                        s_nxt.shreg = down.rd_byte;
                        s_nxt.sda_oe = ~down.rd_byte[7];
                    end else begin
                        s_nxt.phase = PH_WRITE;
                    end
                end
                PH_WRITE: begin
                    s_nxt.phase = PH_WRITE;
                end
                PH_READ: begin
                    if (sda_i) begin
                        // master did not acknowledge: stay off the line
                        s_nxt.phase = PH_SKIP;
                    end else begin
                        s_nxt.shreg = down.rd_byte;
                        s_nxt.sda_oe = ~down.rd_byte[7];
                    end
                end
                PH_SKIP: begin
                    s_nxt.phase = PH_SKIP;
                end
            endcase
        end else begin
            s_nxt.fall_cnt = n;
            if (s_r.phase == PH_READ) begin
                s_nxt.sda_oe = ~s_r.shreg[6];
                s_nxt.shreg = {s_r.shreg[6:0], 1'b0};
            end else begin
                s_nxt.shreg = full;
            end
        end
    end

    always_ff @(negedge scl or posedge link_clr) begin
        if (link_clr) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign up = s_r.up;
    assign sda_oe = s_r.sda_oe;

endmodule

// ---- src/i2c_output_port_expander.sv ----
`timescale 1ns/100ps
`include "expander_map.svh"

module i2c_output_port_expander (
    input wire logic mclk,
    input wire logic srst,
    input wire logic scl,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    input wire logic iface_rst_n,
    input wire logic addr_sel_low,
    input wire logic addr_sel_high,
    input wire logic [7:0] port_level_in,
    output logic [7:0] push_pull_outs
);
    import expander_pkg::*;

    core_state_t s_r;
    core_state_t s_nxt;
    link_up_t up;
    logic sel_lvl [1:0];
    logic scl_s;
    logic sda_s;
    logic start;
    logic stop;
    logic rise;
    logic fall;
    logic pin_rst;
    logic wr_evt;
    logic [3:0] rise_next;

    // a select that never differed from a bus line during the frame follows it
    function automatic pin_class_t classify(input logic lvl, input logic dscl,
                                            input logic dsda);
        if (!dscl) begin
            classify = PC_SCL;
        end else if (!dsda) begin
            classify = PC_SDA;
        end else if (lvl) begin
            classify = PC_VCC;
        end else begin
            classify = PC_GND;
        end
    endfunction

    // power-up level for one group of four outputs
    function automatic logic [3:0] group_default(input pin_class_t c);
        if (c == PC_GND) begin
            group_default = `GROUP_LOW;
        end else begin
            group_default = `GROUP_HIGH;
        end
    endfunction

    i2c_link link_u (
        .scl(scl),
        .link_clr(s_r.link_clr),
        .sda_i(sda_i),
        .down(s_r.down),
        .up(up),
        .sda_oe(sda_oe)
    );

    always_comb begin
        s_nxt = s_r;

        // two-stage synchronisers for every pin and for the link's write toggle; wr_byte is taken unsynchronised
        s_nxt.scl_m = {s_r.scl_m[0], scl};
        s_nxt.sda_m = {s_r.sda_m[0], sda_i};
        s_nxt.rstp_m = {s_r.rstp_m[0], iface_rst_n};
        s_nxt.sel_m[`SEL_LOW] = {s_r.sel_m[`SEL_LOW][0], addr_sel_low};
        s_nxt.sel_m[`SEL_HIGH] = {s_r.sel_m[`SEL_HIGH][0], addr_sel_high};
        s_nxt.pins_a = port_level_in;
        s_nxt.pins_b = s_r.pins_a;
        s_nxt.wtg_m = {s_r.wtg_m[0], up.wr_tgl};
        s_nxt.wtg_d = s_r.wtg_m[1];

        scl_s = s_r.scl_m[1];
        sda_s = s_r.sda_m[1];
        for (int i = 0; i < 2; i++) begin
            sel_lvl[i] = s_r.sel_m[i][1];
        end
        s_nxt.scl_d = scl_s;
        s_nxt.sda_d = sda_s;

        start = scl_s & s_r.scl_d & s_r.sda_d & ~sda_s;
        stop = scl_s & s_r.scl_d & ~s_r.sda_d & sda_s;
        rise = scl_s & ~s_r.scl_d;
        fall = ~scl_s & s_r.scl_d;
        pin_rst = ~s_r.rstp_m[1];

        if (s_r.rise_cnt == `RISE_ACK) begin
            rise_next = `RISE_ONE;
        end else begin
            rise_next = s_r.rise_cnt + `RISE_ONE;
        end

        // watch whether each select follows scl or sda during the frame
        if (s_r.busy) begin
            for (int i = 0; i < 2; i++) begin
                if (sel_lvl[i] != scl_s) begin
                    s_nxt.diff_scl[i] = 1'b1;
                end
                if (sel_lvl[i] != sda_s) begin
                    s_nxt.diff_sda[i] = 1'b1;
                end
            end
        end

        // before any frame the selects read as plain levels
        if (!s_r.framed_once) begin
            for (int i = 0; i < 2; i++) begin
                s_nxt.cls[i] = sel_lvl[i] ? PC_VCC : PC_GND;
            end
            s_nxt.down.slave_low4 = {s_nxt.cls[`SEL_HIGH], s_nxt.cls[`SEL_LOW]};
        end

        if (rise && s_r.busy) begin
            s_nxt.rise_cnt = rise_next;
            // address is fixed once seven bits have gone by on any frame
            if (s_r.first_byte && rise_next == `RISE_ADDR_SNAP) begin
                for (int i = 0; i < 2; i++) begin
                    s_nxt.cls[i] = classify(sel_lvl[i], s_r.diff_scl[i],
                                            s_r.diff_sda[i]);
                end
                s_nxt.down.slave_low4 = {s_nxt.cls[`SEL_HIGH], s_nxt.cls[`SEL_LOW]};
                s_nxt.framed_once = 1'b1;
            end
            if (rise_next == `RISE_ACK) begin
                s_nxt.first_byte = 1'b0;
            end
        end

        // sample the pins at the start of every acknowledge bit
        if (fall && s_r.busy && s_r.rise_cnt == `RISE_LAST_BIT) begin
            s_nxt.down.rd_byte = s_r.pins_b;
        end

        if (start) begin
            s_nxt.busy = 1'b1;
            s_nxt.rise_cnt = `RISE_ZERO;
            s_nxt.first_byte = 1'b1;
            s_nxt.diff_scl = '0;
            s_nxt.diff_sda = '0;
        end
        if (stop) begin
            s_nxt.busy = 1'b0;
        end
        if (pin_rst) begin
            s_nxt.busy = 1'b0;
        end

        // link is held cleared while idle and pulsed on each start
        s_nxt.link_clr = start | ~s_nxt.busy;
        s_nxt.clr_hist = {s_r.clr_hist[1:0], s_r.link_clr};

        // a clear resets the link toggle, so ignore edges around a clear
        wr_evt = (s_r.wtg_m[1] != s_r.wtg_d) & ~s_r.link_clr & ~(|s_r.clr_hist);
        if (wr_evt) begin
            s_nxt.port = up.wr_byte;
        end

        // the pin reset never touches the output byte
        if (s_r.strap_pend) begin
            if (s_r.strap_wait == `STRAP_DONE) begin
                s_nxt.strap_pend = 1'b0;
                s_nxt.port = {group_default(s_r.cls[`SEL_HIGH]),
                              group_default(s_r.cls[`SEL_LOW])};
            end else begin
                s_nxt.strap_wait = s_r.strap_wait - `STRAP_STEP;
            end
        end

        s_nxt.sda_o = 1'b0;

        if (srst) begin
            s_nxt = '0;
            s_nxt.link_clr = 1'b1;
            s_nxt.clr_hist = '1;
            s_nxt.port = `PORT_RESET;
            s_nxt.strap_pend = 1'b1;
            s_nxt.strap_wait = `STRAP_WAIT;
        end
    end

    always_ff @(posedge mclk) begin
        s_r <= s_nxt;
    end

    assign push_pull_outs = s_r.port;
    assign sda_o = s_r.sda_o;

endmodule

// ---- tb/expander_chk.sv ----
`timescale 1ns/100ps
module expander_chk (
    input wire logic mclk,
    input wire logic srst,
    input wire logic scl,
    input wire logic sda_o,
    input wire logic sda_oe,
    input wire logic iface_rst_n,
    input wire logic addr_sel_low,
    input wire logic addr_sel_high,
    input wire logic [7:0] push_pull_outs
);
    logic [3:0] age_r;
    default clocking @(posedge mclk); endclocking
    default disable iff (srst);
    // cycles since core reset, saturating
    always_ff @(posedge mclk) begin
        if (srst)
            age_r <= 4'h0;
        else if (age_r != 4'hF)
            age_r <= age_r + 4'h1;
    end
    a_reset_zero:
        assert property (disable iff (1'b0) srst ##1 srst |-> push_pull_outs == 8'h00)
        else $error("outputs not cleared in reset");
    a_power_dflt:
        assert property ($fell(srst) |-> ##[3:6]
            push_pull_outs == {{4{addr_sel_high}}, {4{addr_sel_low}}})
        else $error("wrong power-up levels");
    a_sda_low_only:
        assert property (sda_oe |-> sda_o == 1'b0) else $error("sda driven high");
    a_irst_hold:
        assert property (!iface_rst_n [*8] |=> $stable(push_pull_outs))
        else $error("outputs moved in interface reset");
    a_irst_quiet:
        assert property (!iface_rst_n [*6] |-> !sda_oe) else $error("sda held in reset");
    a_oe_scl_low:
        assert property ($changed(sda_oe) |-> !scl || !iface_rst_n)
        else $error("sda moved while scl high");
    a_out_cause:
        assert property ($changed(push_pull_outs) |-> sda_oe || age_r < 4'hA)
        else $error("outputs moved outside a write ack");
    a_oe_min:
        assert property ($rose(sda_oe) |-> (sda_oe || !iface_rst_n) [*6])
        else $error("sda drive too short");
    a_oe_max:
        assert property (sda_oe |-> ##[1:80] !sda_oe) else $error("sda drive stuck");
    cover property ($rose(sda_oe));
    cover property ($changed(push_pull_outs) && sda_oe);
    cover property (!iface_rst_n [*8]);
endmodule

// ---- tb/i2c_host_model.sv ----
`timescale 1ns/100ps
module i2c_host_model (
    output logic scl,
    output logic sda_drv,
    input wire logic sda_i
);
    int lo = 20;
    // clock stands high between frames, released data reads high
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end
    task automatic start();
        sda_drv = 1'b0;
        #120 scl = 1'b0;
    endtask
    task automatic stop();
        #20 sda_drv = 1'b0;
        #20 scl = 1'b1;
        #40 sda_drv = 1'b1;
        #200;
    endtask
    // eight bits then the ninth, msb first; rx holds the wire at each high phase
    task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
        for (int i = 8; i >= 0; i--) begin
            #(lo) sda_drv = tx[i];
            #20 scl = 1'b1;
            #20 rx[i] = sda_i;
            #20 scl = 1'b0;
        end
    endtask
endmodule

// ---- tb/i2c_output_port_expander_test.sv ----
`timescale 1ns/100ps
module i2c_output_port_expander_test;
    logic mclk = 1'b0;
    logic srst = 1'b1;
    logic iface_rst_n = 1'b1;
    logic [1:0] cls_l = 2'h0;
    logic [1:0] cls_h = 2'h2;
    logic [7:0] frc = 8'h00;
    logic scl, sda_drv, sda, sda_o, sda_oe, sel_l, sel_h;
    logic [7:0] outs;
    logic [8:0] rx;
    int err_count = 0;
    int tests_run = 0;
    int exp_port;
    always #5 mclk = ~mclk;
    assign sda = sda_drv & ~sda_oe;
    assign sel_l = cls_l[1] ? (cls_l[0] ? scl : sda) : cls_l[0];
    assign sel_h = cls_h[1] ? (cls_h[0] ? scl : sda) : cls_h[0];
    i2c_host_model m_u (.scl(scl), .sda_drv(sda_drv), .sda_i(sda));
    i2c_output_port_expander dut_u (.mclk(mclk), .srst(srst), .scl(scl), .sda_i(sda),
        .sda_o(sda_o), .sda_oe(sda_oe), .iface_rst_n(iface_rst_n), .addr_sel_low(sel_l),
        .addr_sel_high(sel_h), .port_level_in(outs ^ frc), .push_pull_outs(outs));
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic conclude();
        if (err_count == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic addr(input logic [6:0] a, input logic rw, input logic hit);
        @(negedge mclk);
        m_u.start();
        m_u.xfer({a, rw, 1'b1}, rx);
        check("addr ack", {7'h0, rx[0]}, {7'h0, ~hit});
    endtask
    task automatic wbyte(input logic [7:0] d, input logic hit);
        m_u.xfer({d, 1'b1}, rx);
        if (hit)
            exp_port = d;
        check("data ack", {7'h0, rx[0]}, {7'h0, ~hit});
        check("outputs", outs, exp_port[7:0]);
    endtask
    task automatic rbyte(input logic last, input logic [7:0] f);
        m_u.xfer({8'hFF, last}, rx);
        check("readback", rx[8:1], exp_port[7:0] ^ f);
    endtask
    initial begin
        #800000;
        err_count++;
        conclude();
    end
    initial begin
        logic [7:0] d;
        logic [7:0] f;
        logic [6:0] a;
        void'($urandom(23551));
        repeat (2) @(negedge mclk);
        srst = 1'b0;
        repeat (12) @(negedge mclk);
        check("power-up", outs, 8'hF0);
        exp_port = 8'hF0;
        for (int c = 0; c < 16; c++) begin
            cls_h = c[3:2];
            cls_l = c[1:0];
            a = {3'h5, cls_h, cls_l};
            d = $urandom;
            addr(a ^ 7'h20, 1'b0, 1'b0);
            wbyte(d, 1'b0);
            m_u.stop();
            addr(a, 1'b0, 1'b1);
            wbyte(d, 1'b1);
            wbyte(~d, 1'b1);
            m_u.stop();
            f = $urandom;
            frc = f;
            addr(a, 1'b1, 1'b1);
            frc = $urandom;
            rbyte(1'b0, f);
            rbyte(1'b1, frc);
            m_u.stop();
        end
        // interface reset after an acked address voids the rest of the frame
        addr(a, 1'b0, 1'b1);
        iface_rst_n = 1'b0;
        wbyte(8'h3C, 1'b0);
        iface_rst_n = 1'b1;
        m_u.stop();
        addr(a, 1'b0, 1'b1);
        wbyte(8'h3C, 1'b1);
        m_u.stop();
        conclude();
    end
endmodule
bind i2c_output_port_expander expander_chk chk_u (.mclk, .srst, .scl, .sda_o, .sda_oe,
    .iface_rst_n, .addr_sel_low, .addr_sel_high, .push_pull_outs);
